// ### inc/spmc_pkg.sv
// spmc_pkg: constants and types for the switch power mode controller
// assumes a 40 MHz system clock and an 8-bit register port
package spmc_pkg;
    // ==========================================
    // register offsets
    localparam logic [7:0] SPMC_OFF_MODE  = 8'h0E;
    localparam logic [7:0] SPMC_OFF_SLEEP = 8'h0F;
    localparam logic [7:0] SPMC_OFF_P1X   = 8'h1D;
    localparam logic [7:0] SPMC_OFF_P2X   = 8'h2D;
    localparam logic [7:0] SPMC_OFF_P3X   = 8'h3D;
    localparam logic [7:0] SPMC_OFF_P4X   = 8'h4D;
    localparam logic [7:0] SPMC_OFF_STAT  = 8'hF0;
    // ==========================================
    // fields and reset values
    localparam int         SPMC_MODE_LSB  = 3;
    localparam int         SPMC_PDN_BIT   = 3;
    localparam logic [7:0] SPMC_MODE_RST  = 8'h00;
    localparam logic [7:0] SPMC_SLEEP_RST = 8'h50;
    localparam logic [7:0] SPMC_PX_RST    = 8'h00;
    localparam int         SPMC_PORTS     = 4;
    // ==========================================
    // timing
    localparam int SPMC_CLK_HZ       = 40_000_000;
    localparam int SPMC_PULSE_NS     = 120;
    localparam int SPMC_PULSE_CYC    = (SPMC_PULSE_NS * 40 + 999) / 1000;
    localparam int SPMC_PERIOD_S     = 1;
    localparam int SPMC_PERIOD_CYC   = SPMC_PERIOD_S * SPMC_CLK_HZ;
    localparam int SPMC_SLEEP_UNIT_MS = 1;
    localparam int SPMC_SLEEP_UNIT_CYC = SPMC_SLEEP_UNIT_MS * (SPMC_CLK_HZ / 1000);
    // ==========================================
    // shared memory organisation
    localparam int SPMC_BUF_COUNT = 512;
    localparam int SPMC_BUF_BYTES = 128;

    typedef enum logic [1:0] {
        SPMC_MODE_NORMAL = 2'b00,
        SPMC_MODE_EDET   = 2'b01,
        SPMC_MODE_SOFTPD = 2'b10,
        SPMC_MODE_RSVD   = 2'b11
    } spmc_mode_type;

    typedef struct packed {
        logic pll_en;
        logic phy_en;
        logic mac_en;
        logic host_en;
        logic rx_edet_en;
    } spmc_enables_type;

    typedef struct packed {
        logic [7:0] addr;
        logic [7:0] wdata;
        logic       wr;
        logic       rd;
    } spmc_bus_type;
endpackage

// ### src/spmc_ctrl.sv
// spmc_ctrl: power mode controller with register port, sleep timer, link pulse and clock gating
// assumes synchronous host strobes on i_sys_clk; energy and lpi inputs come from pins
module spmc_ctrl
    import spmc_pkg::*;
#(
    parameter int PULSE_PERIOD_CYC = SPMC_PERIOD_CYC,
    parameter int SLEEP_UNIT_CYC   = SPMC_SLEEP_UNIT_CYC,
    parameter int BUF_COUNT        = SPMC_BUF_COUNT,
    parameter int BUF_BYTES        = SPMC_BUF_BYTES
) (
    input  wire logic                    i_sys_clk,     // system clock
    input  wire logic                    i_sys_rst,     // synchronous reset, high
    input  wire logic                    i_clk_en,      // freezes all state when low
    input  wire spmc_bus_type            i_bus,         // host address, data, strobes
    output logic [7:0]                   o_rdata,       // read data, cycle after read
    input  wire logic                    i_energy,      // cable energy seen, async
    input  wire logic [SPMC_PORTS-1:0]   i_phy_bit11,   // phy control bit 11 per port
    input  wire logic [SPMC_PORTS-1:0]   i_lpi_tx,      // tx lpi active per port, async
    input  wire logic [SPMC_PORTS-1:0]   i_lpi_rx,      // rx lpi active per port, async
    output spmc_enables_type             o_en,          // block enables
    output logic [SPMC_PORTS-1:0]        o_port_pdn,    // per-port power-down
    output logic [SPMC_PORTS-1:0]        o_tx_clk_en,   // tx clock gate per port
    output logic [SPMC_PORTS-1:0]        o_rx_clk_en,   // rx clock gate per port
    output logic                         o_sw_clk_en,   // switch core clock gate
    output logic                         o_link_pulse,  // energy detect link pulse
    output logic                         o_low_power,   // low-power state flag
    output logic                         o_int_rst      // internal reset pulse
);
    // ==========================================
    // functions
    function automatic spmc_enables_type mode_enables(input spmc_mode_type m, input logic lp);
        spmc_enables_type e;
        e = '0;
        case (m)
            SPMC_MODE_NORMAL: e = '{1'b1, 1'b1, 1'b1, 1'b1, 1'b1};
            SPMC_MODE_EDET:   e = lp ? '{1'b0, 1'b0, 1'b0, 1'b0, 1'b1}
                                     : '{1'b1, 1'b1, 1'b1, 1'b1, 1'b1};
            SPMC_MODE_SOFTPD: e = '0;
            default:          e = '{1'b1, 1'b1, 1'b1, 1'b1, 1'b1};
        endcase
        return e;
    endfunction

    // status word: port power-down, low-power state, synced energy
    function automatic logic [7:0] status_word(input logic [SPMC_PORTS-1:0] pdn,
                                               input logic                  lp,
                                               input logic                  egy);
        return {2'b00, pdn, lp, egy};
    endfunction

    localparam int MEM_BYTES = BUF_COUNT * BUF_BYTES;

    // ==========================================
    // input synchronisers
    logic                  energy_s1_reg;
    logic                  energy_s2_reg;
    logic [SPMC_PORTS-1:0] ltx_s1_reg;
    logic [SPMC_PORTS-1:0] ltx_s2_reg;
    logic [SPMC_PORTS-1:0] lrx_s1_reg;
    logic [SPMC_PORTS-1:0] lrx_s2_reg;
    logic [SPMC_PORTS-1:0] b11_s1_reg;
    logic [SPMC_PORTS-1:0] b11_s2_reg;

    // cable energy; only the second stage is read by logic
    always_ff @(posedge i_sys_clk) begin
        if (i_sys_rst) begin
            energy_s1_reg <= 1'b0;
            energy_s2_reg <= 1'b0;
        end else if (i_clk_en) begin
            energy_s1_reg <= i_energy;
            energy_s2_reg <= energy_s1_reg;
        end
    end

    // transmit lpi per port
    always_ff @(posedge i_sys_clk) begin
        if (i_sys_rst) begin
            ltx_s1_reg <= '0;
            ltx_s2_reg <= '0;
        end else if (i_clk_en) begin
            ltx_s1_reg <= i_lpi_tx;
            ltx_s2_reg <= ltx_s1_reg;
        end
    end

    // receive lpi per port
    always_ff @(posedge i_sys_clk) begin
        if (i_sys_rst) begin
            lrx_s1_reg <= '0;
            lrx_s2_reg <= '0;
        end else if (i_clk_en) begin
            lrx_s1_reg <= i_lpi_rx;
            lrx_s2_reg <= lrx_s1_reg;
        end
    end

    // phy control bit 11 per port
    always_ff @(posedge i_sys_clk) begin
        if (i_sys_rst) begin
            b11_s1_reg <= '0;
            b11_s2_reg <= '0;
        end else if (i_clk_en) begin
            b11_s1_reg <= i_phy_bit11;
            b11_s2_reg <= b11_s1_reg;
        end
    end

    // ==========================================
    // registers
    logic [7:0]            mode_reg;
    logic [7:0]            sleep_reg;
    logic [7:0]            px_reg [SPMC_PORTS];
    logic                  int_rst_reg;
    spmc_mode_type         mode;
    logic                  host_access;
    logic                  wake;
    logic [1:0]            wmode;

    assign mode        = spmc_mode_type'(mode_reg[SPMC_MODE_LSB +: 2]);
    assign host_access = i_bus.wr | i_bus.rd;
    assign wake        = (mode == SPMC_MODE_SOFTPD) && host_access;
    assign wmode       = i_bus.wdata[SPMC_MODE_LSB +: 2];

    // internal reset pulse after soft power-down wake
    always_ff @(posedge i_sys_clk) begin
        if (i_sys_rst) begin
            int_rst_reg <= 1'b0;
        end else if (i_clk_en) begin
            int_rst_reg <= wake;
        end
    end

    // mode register; a wake access is consumed, not stored
    always_ff @(posedge i_sys_clk) begin
        if (i_sys_rst || int_rst_reg) begin
            mode_reg <= SPMC_MODE_RST;
        end else if (i_clk_en) begin
            if (wake) begin
                mode_reg <= SPMC_MODE_RST;
            end else if (i_bus.wr && i_bus.addr == SPMC_OFF_MODE) begin
                if (wmode != SPMC_MODE_RSVD) begin
                    mode_reg <= i_bus.wdata;
                end else begin
                    mode_reg <= {i_bus.wdata[7:5], mode_reg[4:3], i_bus.wdata[2:0]};
                end
            end
        end
    end

    // sleep delay register
    always_ff @(posedge i_sys_clk) begin
        if (i_sys_rst || int_rst_reg) begin
            sleep_reg <= SPMC_SLEEP_RST;
        end else if (i_clk_en && !wake && i_bus.wr) begin
            if (i_bus.addr == SPMC_OFF_SLEEP) begin
                sleep_reg <= i_bus.wdata;
            end
        end
    end

    // per-port control registers, one stride apart
    always_ff @(posedge i_sys_clk) begin
        if (i_sys_rst || int_rst_reg) begin
            for (int p = 0; p < SPMC_PORTS; p++) begin
                px_reg[p] <= SPMC_PX_RST;
            end
        end else if (i_clk_en && !wake && i_bus.wr) begin
            for (int p = 0; p < SPMC_PORTS; p++) begin
                if (i_bus.addr == (SPMC_OFF_P1X + 8'((p) * 16))) begin
                    px_reg[p] <= i_bus.wdata;
                end
            end
        end
    end

    // ==========================================
    // go-sleep timer and low-power state
    logic [$clog2(SLEEP_UNIT_CYC+1)-1:0] unit_cnt_reg;
    logic [8:0]                          sleep_cnt_reg;
    logic                                low_power_reg;
    logic                                quiet_expired;

    assign quiet_expired = (sleep_cnt_reg > {1'b0, sleep_reg});

    always_ff @(posedge i_sys_clk) begin
        if (i_sys_rst || int_rst_reg) begin
            unit_cnt_reg  <= '0;
            sleep_cnt_reg <= '0;
        end else if (i_clk_en) begin
            if (mode != SPMC_MODE_EDET || energy_s2_reg || low_power_reg) begin
                unit_cnt_reg  <= '0;
                sleep_cnt_reg <= '0;
            end else if (unit_cnt_reg == ($bits(unit_cnt_reg))'(SLEEP_UNIT_CYC - 1)) begin
                unit_cnt_reg <= '0;
                if (!quiet_expired) begin
                    sleep_cnt_reg <= sleep_cnt_reg + 9'h001;
                end
            end else begin
                unit_cnt_reg <= unit_cnt_reg + 1'b1;
            end
        end
    end

    always_ff @(posedge i_sys_clk) begin
        if (i_sys_rst || int_rst_reg) begin
            low_power_reg <= 1'b0;
        end else if (i_clk_en) begin
            if (mode != SPMC_MODE_EDET || energy_s2_reg) begin
                low_power_reg <= 1'b0;
            end else if (quiet_expired) begin
                low_power_reg <= 1'b1;
            end
        end
    end

    // ==========================================
    // link pulse in energy detect mode without cable
    logic [$clog2(PULSE_PERIOD_CYC+1)-1:0] pulse_cnt_reg;
    logic                                  link_pulse_reg;

    // period counter; restarts so a pulse opens each quiet spell
    always_ff @(posedge i_sys_clk) begin
        if (i_sys_rst || int_rst_reg) begin
            pulse_cnt_reg <= '0;
        end else if (i_clk_en) begin
            if (mode != SPMC_MODE_EDET || energy_s2_reg) begin
                pulse_cnt_reg <= '0;
            end else if (pulse_cnt_reg == ($bits(pulse_cnt_reg))'(PULSE_PERIOD_CYC - 1)) begin
                pulse_cnt_reg <= '0;
            end else begin
                pulse_cnt_reg <= pulse_cnt_reg + 1'b1;
            end
        end
    end

    // pulse high for the first cycles of each period
    always_ff @(posedge i_sys_clk) begin
        if (i_sys_rst || int_rst_reg) begin
            link_pulse_reg <= 1'b0;
        end else if (i_clk_en) begin
            if (mode != SPMC_MODE_EDET || energy_s2_reg) begin
                link_pulse_reg <= 1'b0;
            end else begin
                link_pulse_reg <= (pulse_cnt_reg < ($bits(pulse_cnt_reg))'(SPMC_PULSE_CYC));
            end
        end
    end

    // ==========================================
    // enables, port power-down and lpi clock gating
    spmc_enables_type      en_next;
    logic [SPMC_PORTS-1:0] pdn_next;

    assign en_next = mode_enables(mode, low_power_reg);

    always_comb begin
        for (int p = 0; p < SPMC_PORTS; p++) begin
            pdn_next[p] = px_reg[p][SPMC_PDN_BIT] | b11_s2_reg[p];
        end
    end

    // block enables
    always_ff @(posedge i_sys_clk) begin
        if (i_sys_rst) begin
            o_en <= '{1'b1, 1'b1, 1'b1, 1'b1, 1'b1};
        end else if (i_clk_en) begin
            o_en <= en_next;
        end
    end

    // port power-down; a disabled phy forces every port down
    always_ff @(posedge i_sys_clk) begin
        if (i_sys_rst) begin
            o_port_pdn <= '0;
        end else if (i_clk_en) begin
            o_port_pdn <= pdn_next | {SPMC_PORTS{~en_next.phy_en}};
        end
    end

    // gating only stops clocks; link status and frames untouched
    always_ff @(posedge i_sys_clk) begin
        if (i_sys_rst) begin
            o_tx_clk_en <= '1;
        end else if (i_clk_en) begin
            o_tx_clk_en <= ~ltx_s2_reg & {SPMC_PORTS{en_next.mac_en}};
        end
    end

    // receive side gated on its own lpi and mac_en only
    always_ff @(posedge i_sys_clk) begin
        if (i_sys_rst) begin
            o_rx_clk_en <= '1;
        end else if (i_clk_en) begin
            o_rx_clk_en <= ~lrx_s2_reg & {SPMC_PORTS{en_next.mac_en}};
        end
    end

    // switch core stops when pll_en drops or every port idles both ways
    always_ff @(posedge i_sys_clk) begin
        if (i_sys_rst) begin
            o_sw_clk_en <= 1'b1;
        end else if (i_clk_en) begin
            o_sw_clk_en <= en_next.pll_en & ~(&(ltx_s2_reg & lrx_s2_reg));
        end
    end

    // ==========================================
    // read port
    always_ff @(posedge i_sys_clk) begin
        if (i_sys_rst) begin
            o_rdata <= '0;
        end else if (i_clk_en) begin
            o_rdata <= '0;
            if (i_bus.rd && !wake) begin
                case (i_bus.addr)
                    SPMC_OFF_MODE:  o_rdata <= mode_reg;
                    SPMC_OFF_SLEEP: o_rdata <= sleep_reg;
                    SPMC_OFF_P1X:   o_rdata <= px_reg[0];
                    SPMC_OFF_P2X:   o_rdata <= px_reg[1];
                    SPMC_OFF_P3X:   o_rdata <= px_reg[2];
                    SPMC_OFF_P4X:   o_rdata <= px_reg[3];
                    SPMC_OFF_STAT:  o_rdata <= status_word(o_port_pdn, low_power_reg, energy_s2_reg);
                    default:        o_rdata <= '0;
                endcase
            end
        end
    end

    // ==========================================
    // output copies, aligned with the enables
    always_ff @(posedge i_sys_clk) begin
        if (i_sys_rst) begin
            o_link_pulse <= 1'b0;
        end else if (i_clk_en) begin
            o_link_pulse <= link_pulse_reg;
        end
    end

    // same edge as o_en; o_low_power lags o_en one edge when the mode leaves energy detect
    always_ff @(posedge i_sys_clk) begin
        if (i_sys_rst) begin
            o_low_power <= 1'b0;
        end else if (i_clk_en) begin
            o_low_power <= low_power_reg;
        end
    end

    // one cycle wide; sleep and port registers clear on the edge it rises, mode register one edge earlier
    always_ff @(posedge i_sys_clk) begin
        if (i_sys_rst) begin
            o_int_rst <= 1'b0;
        end else if (i_clk_en) begin
            o_int_rst <= int_rst_reg;
        end
    end
endmodule

// ### verif/spmc_ctrl_chk.sv
// spmc_ctrl_chk: port-level checks on the power mode controller
// assumes a bind into spmc_ctrl, one clock, synchronous active-high reset
module spmc_ctrl_chk
    import spmc_pkg::*;
(
    input wire logic             i_sys_clk,    // clock
    input wire logic             i_sys_rst,    // reset
    input wire spmc_bus_type     i_bus,        // host port
    input wire logic             i_energy,     // cable energy
    input wire logic [3:0]       i_lpi_tx,     // tx lpi
    input wire logic [3:0]       i_lpi_rx,     // rx lpi
    input wire logic [7:0]       o_rdata,      // read data
    input wire spmc_enables_type o_en,         // enables
    input wire logic [3:0]       o_port_pdn,   // port down
    input wire logic [3:0]       o_tx_clk_en,  // tx gate
    input wire logic [3:0]       o_rx_clk_en,  // rx gate
    input wire logic             o_link_pulse, // link pulse
    input wire logic             o_low_power,  // low power
    input wire logic             o_int_rst     // internal reset
);
    // ==========================================
    // checks
    default clocking @(posedge i_sys_clk); endclocking
    default disable iff (i_sys_rst);
    sequence s_pulse_hi;
        o_link_pulse [*5] ##1 !o_link_pulse;
    endsequence
    sequence s_tx_idle;
        (i_lpi_tx[0] && !i_lpi_rx[0] && o_en.mac_en) [*5];
    endsequence
    a_rdata_idle: assert property (!i_bus.rd |=> o_rdata == 8'h00)
        else $error("read data not zero outside read answer");
    a_low_only_rx: assert property (o_low_power |-> o_en == 5'h01)
        else $error("low power keeps more than energy detect");
    a_energy_wake: assert property (o_low_power && i_energy |-> ##[1:4] !o_low_power)
        else $error("energy did not leave low power");
    a_pulse_width: assert property ($rose(o_link_pulse) |-> s_pulse_hi)
        else $error("link pulse width wrong");
    a_softpd_ports: assert property (o_en == 5'h00 |-> o_port_pdn == 4'hF)
        else $error("ports up while all blocks off");
    a_access_wakes: assert property (o_en == 5'h00 && (i_bus.wr || i_bus.rd) |-> ##[1:3] o_int_rst)
        else $error("host access did not wake");
    a_intrst_once: assert property (o_int_rst |=> !o_int_rst)
        else $error("internal reset longer than one cycle");
    a_wake_normal: assert property (o_int_rst |-> ##[1:3] o_en == 5'h1F)
        else $error("wake did not restore normal enables");
    a_lpi_dir: assert property (s_tx_idle |-> !o_tx_clk_en[0] && o_rx_clk_en[0])
        else $error("lpi gating not per direction");
endmodule

// ### verif/spmc_ctrl_tb.sv
// spmc_ctrl_tb: self-checking bench for the power mode controller
// assumes spmc_pkg, spmc_ctrl, spmc_host and spmc_ctrl_chk compiled first
module spmc_ctrl_tb
    import spmc_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    // ==========================================
    // signals and instances
    logic             sys_clk = 1'h0;
    logic             sys_rst = 1'h1;
    logic             energy  = 1'h1;
    logic [3:0]       bit11 = 4'h0, lpi_tx = 4'h0, lpi_rx = 4'h0, pdn, tx_en, rx_en;
    spmc_bus_type     bus;
    spmc_enables_type en;
    logic [7:0]       rdata;
    logic [7:0]       d[4];
    logic             sw_en, pulse, low, irst;
    logic             rd_d = 1'h0;
    logic             clk_en = 1'h1;
    logic [7:0]       exp_q[$];
    int               miscompares = 0, compares = 0, n, s;
    always #12.5 sys_clk = ~sys_clk;
    spmc_host host (.i_sys_clk(sys_clk), .o_bus(bus));
    spmc_ctrl #(.PULSE_PERIOD_CYC(50), .SLEEP_UNIT_CYC(4)) dut (
        .i_sys_clk(sys_clk), .i_sys_rst(sys_rst), .i_clk_en(clk_en), .i_bus(bus), .o_rdata(rdata),
        .i_energy(energy), .i_phy_bit11(bit11), .i_lpi_tx(lpi_tx), .i_lpi_rx(lpi_rx), .o_en(en),
        .o_port_pdn(pdn), .o_tx_clk_en(tx_en), .o_rx_clk_en(rx_en), .o_sw_clk_en(sw_en),
        .o_link_pulse(pulse), .o_low_power(low), .o_int_rst(irst));
    // ==========================================
    // tasks
    task automatic results;
        $display("compares %0d miscompares %0d", compares, miscompares);
        if (miscompares == 0 && compares > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask
    task automatic chk_sig(input logic [7:0] e, input logic [7:0] g);
        compares++;
        if (g !== e) begin
            miscompares++;
            $display("Error at %0t: expected %h got %h", $time, e, g);
        end
    endtask
    task automatic chk_rd(input logic [7:0] e, input logic [7:0] g);
        chk_sig(e, g);
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] v);
        host.access(a, v, 1'h1);
    endtask
    task automatic rd(input logic [7:0] a, input logic [7:0] e);
        exp_q.push_back(e);
        host.access(a, 8'h00, 1'h0);
    endtask
    function automatic logic pick(input int k);
        return k == 0 ? low : (k == 1 ? pulse : irst);
    endfunction
    task automatic wait_for(input int k, input logic v, input int lim);
        n = 0;
        while (pick(k) !== v) begin
            @(posedge sys_clk);
            n++;
            if (n > lim) begin
                miscompares++;
                results();
            end
        end
    endtask
    // read answers against the oldest note
    always @(posedge sys_clk) begin
        if (rd_d) chk_rd(exp_q.pop_front(), rdata);
        rd_d <= bus.rd;
    end
    // ==========================================
    // scenarios
    initial begin
        void'($urandom(53072));
        repeat (6) @(posedge sys_clk);
        sys_rst <= 1'h0;
        @(posedge sys_clk);
        rd(SPMC_OFF_MODE, SPMC_MODE_RST);
        rd(SPMC_OFF_SLEEP, SPMC_SLEEP_RST);
        rd(8'h77, 8'h00);
        wr(SPMC_OFF_MODE, 8'h18);
        rd(SPMC_OFF_MODE, 8'h00);
        bit11 <= 4'($urandom);
        for (int i = 0; i < 4; i++) begin
            d[i] = 8'($urandom);
            wr(8'h1D + 8'(i * 16), d[i]);
        end
        for (int i = 0; i < 4; i++) rd(8'h1D + 8'(i * 16), d[i]);
        host.idle(5);
        chk_sig({4'h0, bit11 | {d[3][3], d[2][3], d[1][3], d[0][3]}}, {4'h0, pdn});
        $display("test registers done");
        s = 2 + $urandom % 7;
        wr(SPMC_OFF_SLEEP, 8'(s));
        wr(SPMC_OFF_MODE, 8'h08);
        host.idle(3);
        energy <= 1'h0;
        repeat (s * 4) @(posedge sys_clk);
        energy <= 1'h1;
        repeat (2) @(posedge sys_clk);
        energy <= 1'h0;
        wait_for(0, 1'h1, 100);
        chk_sig(8'(n >= (s + 1) * 4 && n <= (s + 1) * 4 + 6), 8'h01);
        wait_for(1, 1'h1, 60);
        wait_for(1, 1'h0, 8);
        chk_sig(8'(n), 8'h05);
        energy <= 1'h1;
        wait_for(0, 1'h0, 6);
        $display("test energy_detect done");
        wr(SPMC_OFF_MODE, 8'h00);
        wr(SPMC_OFF_MODE, 8'h10);
        host.idle(4);
        chk_sig({3'h0, en}, 8'h00);
        chk_sig({4'h0, pdn}, 8'h0F);
        rd(SPMC_OFF_SLEEP, 8'h00);
        host.idle(0);
        wait_for(2, 1'h1, 6);
        host.idle(3);
        rd(SPMC_OFF_MODE, SPMC_MODE_RST);
        rd(SPMC_OFF_SLEEP, SPMC_SLEEP_RST);
        rd(SPMC_OFF_P1X, SPMC_PX_RST);
        host.idle(2);
        $display("test soft_power_down done");
        bit11 <= 4'h0;
        lpi_tx <= 4'h1;
        lpi_rx <= 4'h2;
        repeat (8) @(posedge sys_clk);
        for (int i = 0; i < 3; i++) begin
            chk_sig({tx_en, rx_en}, {~lpi_tx, ~lpi_rx});
            chk_sig({7'h0, sw_en}, {7'h0, ~&(lpi_tx & lpi_rx)});
            lpi_tx <= i == 1 ? 4'hF : 4'($urandom);
            lpi_rx <= i == 1 ? 4'hF : 4'($urandom);
            repeat (8) @(posedge sys_clk);
        end
        $display("test lpi_gating done");
        lpi_tx <= 4'h0;
        lpi_rx <= 4'h0;
        repeat (8) @(posedge sys_clk);
        clk_en <= 1'h0;
        lpi_rx <= 4'h8;
        repeat (8) @(posedge sys_clk);
        chk_sig({4'h0, rx_en}, 8'h0F);
        clk_en <= 1'h1;
        repeat (8) @(posedge sys_clk);
        chk_sig({4'h0, rx_en}, 8'h07);
        $display("test clock_enable done");
        results();
    end
endmodule

bind spmc_ctrl spmc_ctrl_chk u_chk (.i_sys_clk, .i_sys_rst, .i_bus, .i_energy, .i_lpi_tx, .i_lpi_rx, .o_rdata,
    .o_en, .o_port_pdn, .o_tx_clk_en, .o_rx_clk_en, .o_link_pulse, .o_low_power, .o_int_rst);

// ### verif/spmc_host.sv
// spmc_host: host processor model driving the register port
// assumes its tasks are entered right after a rising clock edge
module spmc_host
    import spmc_pkg::*;
(
    input  wire logic    i_sys_clk, // clock
    output spmc_bus_type o_bus      // host port
);
    // ==========================================
    // bus cycles
    initial o_bus = '0;
    task automatic access(input logic [7:0] a, input logic [7:0] d, input logic w);
        o_bus <= '{addr: a, wdata: d, wr: w, rd: !w};
        @(posedge i_sys_clk);
    endtask
    task automatic idle(input int n);
        o_bus <= '0;
        repeat (n) @(posedge i_sys_clk);
    endtask
endmodule
